// ===== verilog/flash_front_pkg.sv
/*
 * Constants, types and decode functions for the serial flash front end.
 * Assumes a 20 MHz system clock; the link clock is supplied by the host.
 */
package flash_front_pkg;
	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_CE_ALT = 8'h60;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_RPD = 8'hAB;
	localparam logic [7:0] OP_PD = 8'hB9;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_CE = 8'hC7;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_OCT_QIO = 8'hE3;
	localparam logic [7:0] OP_WORD_QIO = 8'hE7;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;

	// ************************************************************
	// Status register layout
	// ************************************************************
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_STATUS_PROTECT_LO = 7;
	localparam int SR_STATUS_PROTECT_HI = 8;
	localparam int SR_QE = 9;
	localparam logic [15:0] SR_RESET = 16'h0000;
	// Bits a status write may change: protect, srp, quad enable, complement
	localparam logic [15:0] SR_WRITE_MASK = 16'h43FC;

	// ************************************************************
	// Frame counts and timing
	// ************************************************************
	localparam logic [5:0] OPCODE_LAST = 6'h07;
	localparam logic [5:0] WRSR_LAST = 6'h17;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int CLK_FREQ_MHZ = 20;
	localparam int PUW_TIME_US = 10;
	localparam int PUW_CYCLES = PUW_TIME_US * CLK_FREQ_MHZ;
	localparam int BUSY_TIME_US = 5;
	localparam int BUSY_CYCLES = BUSY_TIME_US * CLK_FREQ_MHZ;

	typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} lane_mode_t;
	typedef enum logic [1:0] {S_READY, S_BUSY, S_POWER_DOWN} sys_state_t;

	// Lanes used by the data phase of an opcode
	function automatic lane_mode_t op_lanes(input logic [7:0] op);
		unique case (op)
			OP_DUAL_OUT, OP_DUAL_IO: op_lanes = LANES_2;
			OP_QUAD_OUT, OP_QUAD_IO, OP_WORD_QIO, OP_OCT_QIO: op_lanes = LANES_4;
			default: op_lanes = LANES_1;
		endcase
	endfunction : op_lanes

	// Clock count after which data is driven out; zero means none
	function automatic logic [5:0] op_start(input logic [7:0] op);
		unique case (op)
			OP_RDSR1, OP_RDSR2: op_start = 6'h08;
			OP_READ: op_start = 6'h20;
			OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT, OP_RPD: op_start = 6'h28;
			OP_DUAL_IO: op_start = 6'h18;
			OP_QUAD_IO: op_start = 6'h14;
			OP_WORD_QIO: op_start = 6'h12;
			OP_OCT_QIO: op_start = 6'h10;
			default: op_start = 6'h00;
		endcase
	endfunction : op_start

	function automatic logic [3:0] lane_width(input lane_mode_t m);
		unique case (m)
			LANES_2: lane_width = 4'h2;
			LANES_4: lane_width = 4'h4;
			default: lane_width = 4'h1;
		endcase
	endfunction : lane_width
endpackage : flash_front_pkg

// ===== verilog/bit_sync.sv
/*
 * Two-stage level synchroniser of parameter width.
 * Assumes each bit changes slowly against the destination clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d_in;
			q_r <= meta_r;
		end
	end
	assign q_out = q_r;
endmodule : bit_sync
`default_nettype wire

// ===== verilog/toggle_sync.sv
/*
 * Turns a toggle from another clock domain into a one-cycle pulse.
 * Assumes toggles are spaced by more than three destination cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module toggle_sync (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tgl_in,
	output logic pulse_out
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= tgl_in;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end
	assign pulse_out = sync_r ^ last_r;
endmodule : toggle_sync
`default_nettype wire

// ===== verilog/flash_front.sv
/*
 * Serial flash front end: link shifter on the host clock, command and
 * status control on the system clock.
 * Assumes the array core supplies read bytes and the host drives the
 * serial clock only while chip select is low.
 */
// What this block does
// - Chip select high deselects and floats every lane output.
// - Busy cycles finish after chip select rises; standby only when idle.
// - No instruction accepted until chip select has fallen once after power-up.
// - Single lane: sample serial_in on rising edges, drive serial_out on falling.
// - Dual and quad lanes drive on falling edges; rising edges sample lane0 only.
// - Clock modes 0 and 3 both work.
// - Opcodes 3Bh and BBh use lane0 and lane1.
// - Quad read opcodes use lane0 to lane3.
// - Quad only with quad_enable; then protect and pause pins are lanes.
// - quad_enable is status bit 9.
// - Pause starts on pause pin fall if clock low, else next falling edge.
// - Pause ends on pause pin rise if clock low, else next falling edge.
// - While paused outputs float, inputs ignored, state kept.
// - Pause unavailable during quad operation.
// - Reset disables everything.
// - Write-type instructions rejected until post_power_write_delay elapses.
// - Latch clear at power-up; program, erase, status write need it set.
// - Completion of program, erase or status write clears the latch.
// - Power-down ignores all but release.
// - Release from power-down is ABh and returns an identifier.
// - Status write gated by protect bits, latch and write-protect pin.
// - Protect bits 0,1 with write-protect low lock the status register.
// - Protection bits are held and shown in the status register.
`timescale 1ns/1ps
`default_nettype none
module flash_front
	import flash_front_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h5A // Arbitrary identifier value
) (
	// System side
	input wire logic clock_in,
	input wire logic reset_n_in,
	// Link
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic lane0_in,
	output logic lane0_out,
	output logic lane0_oe_out,
	input wire logic lane1_in,
	output logic lane1_out,
	output logic lane1_oe_out,
	input wire logic lane2_in,
	output logic lane2_out,
	output logic lane2_oe_out,
	input wire logic lane3_in,
	output logic lane3_out,
	output logic lane3_oe_out,
	// Array core
	input wire logic [7:0] array_byte_in,
	// Status
	output logic [15:0] status_out,
	output logic standby_out,
	output logic powered_down_out
);
	// ************************************************************
	// Link domain
	// ************************************************************
	logic frame_rst_n;
	logic [24:0] link_sync;
	// System registers mirrored into the link domain
	logic [15:0] sr_r, sr_nxt;
	logic pd_r, pd_nxt;
	logic pd_l;
	logic [15:0] sr_l;
	logic [7:0] array_l;
	logic qe_l;
	logic [5:0] cnt_r, cnt_nxt;
	logic [15:0] shift_r, shift_nxt;
	logic [7:0] op_r, op_nxt;
	lane_mode_t mode_r, mode_nxt;
	logic fire;
	logic [23:0] cmd_r, cmd_nxt;
	logic cmd_tgl_r, cmd_tgl_nxt;
	logic paused_r, paused_nxt;
	logic pause_req;
	logic pause_now;
	logic [7:0] out_r, out_nxt;
	logic [3:0] rem_r, rem_nxt;
	logic oen_r, oen_nxt;
	logic may_drive;
	logic [7:0] src_byte;
	logic [3:0] width;
	logic drive;

	// Chip select high clears the whole frame state
	assign frame_rst_n = reset_n_in & ~cs_n_in;

	bit_sync #(.W(25)) u_link_sync (
		.clk_in(sclk_in),
		.rst_n_in(reset_n_in),
		.d_in({pd_r, sr_r, array_byte_in}),
		.q_out(link_sync)
	);
	assign pd_l = link_sync[24];
	assign sr_l = link_sync[23:8];
	assign array_l = link_sync[7:0];
	assign qe_l = sr_l[SR_QE];

	// Rising edges: opcode and write data come in on lane0
	always_comb begin
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		op_nxt = op_r;
		mode_nxt = mode_r;
		fire = 1'b0;
		if (!pause_req) begin
			if (cnt_r != CNT_MAX) begin
				cnt_nxt = cnt_r + 6'h01;
			end
			shift_nxt = {shift_r[14:0], lane0_in};
			if (cnt_r == OPCODE_LAST) begin
				op_nxt = {shift_r[6:0], lane0_in};
				mode_nxt = op_lanes(op_nxt);
				if (mode_nxt == LANES_4 && !qe_l) begin
					mode_nxt = LANES_1;
				end
				fire = (op_nxt != OP_WRSR);
			end
			if (cnt_r == WRSR_LAST && op_r == OP_WRSR) begin
				fire = 1'b1;
			end
		end
	end

	always_ff @(posedge sclk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cnt_r <= '0;
			shift_r <= '0;
			op_r <= 8'h00;
			mode_r <= LANES_1;
			paused_r <= 1'b0;
		end else begin
			paused_r <= paused_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			op_r <= op_nxt;
			mode_r <= mode_nxt;
		end
	end

	// Command handoff survives chip select rising so the system side can read it
	always_comb begin
		cmd_nxt = cmd_r;
		cmd_tgl_nxt = cmd_tgl_r;
		if (fire) begin
			// Status bits 7:0 arrive first, bits 15:8 second
			cmd_nxt = {op_nxt, shift_nxt[7:0], shift_nxt[15:8]};
			cmd_tgl_nxt = ~cmd_tgl_r;
		end
	end

	always_ff @(posedge sclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cmd_r <= '0;
			cmd_tgl_r <= 1'b0;
		end else begin
			cmd_r <= cmd_nxt;
			cmd_tgl_r <= cmd_tgl_nxt;
		end
	end

	// ************************************************************
	// Pause and output shifter
	// ************************************************************
	assign pause_req = ~lane3_in & ~qe_l & (mode_r != LANES_4);
	// Pin level at a rising edge decides that edge and the falling edge after it
	assign paused_nxt = pause_req;
	// Clock low: pin acts at once; clock high: wait for the falling edge
	assign pause_now = sclk_in ? paused_r : pause_req;

	assign may_drive = (op_start(op_r) != 6'h00)
		&& (op_lanes(op_r) != LANES_4 || qe_l)
		&& (!pd_l || op_r == OP_RPD);
	assign width = lane_width(mode_r);

	always_comb begin
		unique case (op_r)
			OP_RDSR1: src_byte = sr_l[7:0];
			OP_RDSR2: src_byte = sr_l[15:8];
			OP_RPD: src_byte = DEVICE_ID;
			default: src_byte = array_l;
		endcase
	end

	// Falling edges: data leaves MSB first, a lane-width slice per edge
	always_comb begin
		out_nxt = out_r;
		rem_nxt = rem_r;
		oen_nxt = oen_r;
		if (!paused_r && may_drive && cnt_r >= op_start(op_r)) begin
			oen_nxt = 1'b1;
			if (!oen_r || rem_r == width) begin
				out_nxt = src_byte;
				rem_nxt = BYTE_BITS;
			end else begin
				out_nxt = out_r << width;
				rem_nxt = rem_r - width;
			end
		end
	end

	always_ff @(negedge sclk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			out_r <= 8'h00;
			rem_r <= 4'h0;
			oen_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			rem_r <= rem_nxt;
			oen_r <= oen_nxt;
		end
	end

	assign drive = oen_r & ~pause_now & ~cs_n_in;
	// Quad places nibble 7:4 on lanes 3:0, so lanes 1/0 carry bits 5/4
	assign lane1_out = (mode_r == LANES_4) ? out_r[5] : out_r[7];
	assign lane0_out = (mode_r == LANES_4) ? out_r[4] : out_r[6];
	assign lane3_out = out_r[7];
	assign lane2_out = out_r[6];
	always_comb begin
		lane0_oe_out = 1'b0;
		lane1_oe_out = 1'b0;
		lane2_oe_out = 1'b0;
		lane3_oe_out = 1'b0;
		unique case (mode_r)
			LANES_1: lane1_oe_out = drive;
			LANES_2: begin
				lane1_oe_out = drive;
				lane0_oe_out = drive;
			end
			LANES_4: begin
				lane3_oe_out = drive;
				lane2_oe_out = drive;
				lane1_oe_out = drive;
				lane0_oe_out = drive;
			end
		endcase
	end
	// ************************************************************
	// System domain
	// ************************************************************
	logic [1:0] pin_sync;
	logic cs_n_s;
	logic wp_n_s;
	logic cmd_pulse;
	logic [7:0] cmd_op;
	logic [15:0] cmd_data;
	sys_state_t st_r, st_nxt;
	logic [15:0] timer_r, timer_nxt;
	logic [15:0] puw_r, puw_nxt;
	logic cs_prev_r, cs_prev_nxt;
	logic armed_r, armed_nxt;
	logic standby_r, standby_nxt;
	logic puw_done;
	logic sr_write_ok;
	logic is_write_op;

	bit_sync #(.W(2)) u_pin_sync (
		.clk_in(clock_in),
		.rst_n_in(reset_n_in),
		.d_in({cs_n_in, lane2_in}),
		.q_out(pin_sync)
	);
	assign cs_n_s = pin_sync[1];
	assign wp_n_s = pin_sync[0];

	toggle_sync u_cmd_sync (
		.clk_in(clock_in),
		.rst_n_in(reset_n_in),
		.tgl_in(cmd_tgl_r),
		.pulse_out(cmd_pulse)
	);
	// Handoff word is held until the next toggle, well after the pulse
	assign cmd_op = cmd_r[23:16];
	assign cmd_data = cmd_r[15:0];

	assign puw_done = (puw_r == 16'h0000);
	assign is_write_op = (cmd_op == OP_PP || cmd_op == OP_QPP || cmd_op == OP_SE
		|| cmd_op == OP_BE32 || cmd_op == OP_BE64 || cmd_op == OP_CE
		|| cmd_op == OP_CE_ALT);
	assign sr_write_ok = sr_r[SR_WEL] && !sr_r[SR_STATUS_PROTECT_HI]
		&& !(sr_r[SR_STATUS_PROTECT_LO] && !wp_n_s && !sr_r[SR_QE]);

	always_comb begin
		st_nxt = st_r;
		sr_nxt = sr_r;
		timer_nxt = timer_r;
		puw_nxt = puw_done ? puw_r : puw_r - 16'h0001;
		cs_prev_nxt = cs_n_s;
		armed_nxt = armed_r | (cs_prev_r & ~cs_n_s);
		unique case (st_r)
			S_READY: begin
				if (cmd_pulse && armed_r) begin
					if (cmd_op == OP_WREN && puw_done) begin
						sr_nxt[SR_WEL] = 1'b1;
					end else if (cmd_op == OP_WRDI) begin
						sr_nxt[SR_WEL] = 1'b0;
					end else if (cmd_op == OP_WRSR && puw_done && sr_write_ok) begin
						// Protection fields latch here and stay visible
						sr_nxt = (sr_r & ~SR_WRITE_MASK) | (cmd_data & SR_WRITE_MASK);
						st_nxt = S_BUSY;
					end else if (is_write_op && puw_done && sr_r[SR_WEL]) begin
						st_nxt = S_BUSY;
					end else if (cmd_op == OP_PD) begin
						st_nxt = S_POWER_DOWN;
					end
					if (st_nxt == S_BUSY) begin
						timer_nxt = 16'(BUSY_CYCLES - 1);
					end
				end
			end
			S_BUSY: begin
				// Runs on whatever chip select does
				if (timer_r == 16'h0000) begin
					st_nxt = S_READY;
					sr_nxt[SR_WEL] = 1'b0;
				end else begin
					timer_nxt = timer_r - 16'h0001;
				end
			end
			S_POWER_DOWN: begin
				if (cmd_pulse && cmd_op == OP_RPD) begin
					st_nxt = S_READY;
				end
			end
		endcase
		sr_nxt[SR_BUSY] = (st_nxt == S_BUSY);
		standby_nxt = cs_n_s && (st_nxt != S_BUSY);
		pd_nxt = (st_nxt == S_POWER_DOWN);
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_r <= S_READY;
			sr_r <= SR_RESET;
			timer_r <= 16'h0000;
			puw_r <= 16'(PUW_CYCLES);
			cs_prev_r <= 1'b0;
			armed_r <= 1'b0;
			standby_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sr_r <= sr_nxt;
			timer_r <= timer_nxt;
			puw_r <= puw_nxt;
			cs_prev_r <= cs_prev_nxt;
			armed_r <= armed_nxt;
			standby_r <= standby_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign status_out = sr_r;
	assign standby_out = standby_r;
	assign powered_down_out = pd_r;

	// ************************************************************
	// Checks
	// ************************************************************
	a_wel_after_done: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(st_r == S_BUSY && timer_r == 16'h0000) |=> !sr_r[SR_WEL] && st_r == S_READY)
		else $error("latch not cleared at completion");
	a_busy_needs_wel: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(st_r == S_READY ##1 st_r == S_BUSY) |-> $past(sr_r[SR_WEL]))
		else $error("busy cycle began without latch");
	a_wel_after_puw: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		$rose(sr_r[SR_WEL]) |-> $past(puw_done))
		else $error("latch set inside write delay");
	a_unarmed_idle: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(!armed_r && st_r == S_READY) |=> st_r == S_READY && !$rose(sr_r[SR_WEL]))
		else $error("instruction taken before chip select fell");
	a_pd_only_rpd: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(st_r == S_POWER_DOWN && !(cmd_pulse && cmd_op == OP_RPD)) |=> st_r == S_POWER_DOWN)
		else $error("power-down left without release");
	a_sr_wp_lock: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		(!sr_r[SR_STATUS_PROTECT_HI] && sr_r[SR_STATUS_PROTECT_LO] && !wp_n_s && !sr_r[SR_QE])
		|=> sr_r[15:2] == $past(sr_r[15:2]))
		else $error("status written while pin locked");
	a_busy_not_standby: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		st_r == S_BUSY |-> !standby_out && status_out[SR_BUSY])
		else $error("standby shown during busy cycle");
	a_cs_high_float: assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cs_n_in |-> !(lane0_oe_out || lane1_oe_out || lane2_oe_out || lane3_oe_out))
		else $error("lane driven while deselected");
	a_pause_freezes: assert property (@(posedge sclk_in) disable iff (!frame_rst_n)
		pause_req |=> cnt_r == $past(cnt_r))
		else $error("count moved while paused");
	a_quad_no_pause: assert property (@(posedge sclk_in) disable iff (!frame_rst_n)
		mode_r == LANES_4 ##1 mode_r == LANES_4 |-> !paused_r)
		else $error("pause taken in quad mode");
	a_quad_needs_qe: assert property (@(posedge sclk_in) disable iff (!frame_rst_n)
		$rose(mode_r == LANES_4) |-> $past(qe_l))
		else $error("quad mode without quad enable");
endmodule : flash_front
`default_nettype wire

// ===== test/spi_host_model.sv
/*
 * Host side of the flash link: makes the link clock, chip select, serial_in
 * and the pause pin, and samples lane1 and lane0 for read data.
 * Assumes the bench resolves every lane from the device output enables.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Link drive
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out,
	output logic pause_n_out,
	// Link sense
	input wire logic lane0_in,
	input wire logic lane1_in
);
	localparam int HALF = 16;

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
		pause_n_out = 1'b1;
	end

	// ************************************************************
	// One framed instruction; clock stands still outside it
	// ************************************************************
	task automatic frame(input logic [7:0] op, input logic [23:0] tx, input int n_tx,
		input int n_rx, input int dual, input int hold, input logic mode3,
		output logic [15:0] rx);
		logic [31:0] sh;
		sh = {op, tx};
		rx = 16'h0000;
		sclk_out = mode3;
		#HALF cs_n_out = 1'b0;
		for (int k = 0; k < 8 + n_tx; k++) begin
			sclk_out = 1'b0;
			mosi_out = sh[31];
			sh = sh << 1;
			#HALF sclk_out = 1'b1;
			#HALF;
		end
		for (int k = 0; k < n_rx; k++) begin
			sclk_out = 1'b0;
			// Released line keeps moving so a stale level never reads as data
			mosi_out = ~mosi_out;
			if (k == hold) begin
				#4 pause_n_out = 1'b0;
				#HALF sclk_out = 1'b1;
				#HALF sclk_out = 1'b0;
				#HALF pause_n_out = 1'b1;
			end
			#HALF rx = (dual != 0) ? {rx[13:0], lane1_in, lane0_in} : {rx[14:0], lane1_in};
			sclk_out = 1'b1;
			#HALF;
		end
		sclk_out = mode3;
		#HALF cs_n_out = 1'b1;
		#HALF;
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ===== test/testbench.sv
/*
 * Self-checking bench for the flash front end with a host model on the link.
 * Assumes the package timing constants (200 cycle write delay, 100 cycle busy).
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clock_in;
	logic reset_n_in;
	logic [7:0] array_byte_in;
	logic wp_n;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic pause_n;
	logic [3:0] oe;
	logic [3:0] dout;
	logic [15:0] status_out;
	logic standby_out;
	logic powered_down_out;
	logic [15:0] rx;
	logic paused_oe;
	logic quad_seen;
	int n_errors = 0;
	int total_checks = 0;
	wire logic lane0_w;
	wire logic lane1_w;
	wire logic lane2_w;
	wire logic lane3_w;

	// Undriven lanes fall back to the host level or an inverted stale value
	assign lane0_w = oe[0] ? dout[0] : mosi;
	assign lane1_w = oe[1] ? dout[1] : ~dout[1];
	assign lane2_w = oe[2] ? dout[2] : wp_n;
	assign lane3_w = oe[3] ? dout[3] : pause_n;

	flash_front #(.DEVICE_ID(8'hC3)) i_flash_front ( // Arbitrary identifier value
		.clock_in(clock_in), .reset_n_in(reset_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.lane0_in(lane0_w), .lane0_out(dout[0]), .lane0_oe_out(oe[0]),
		.lane1_in(lane1_w), .lane1_out(dout[1]), .lane1_oe_out(oe[1]),
		.lane2_in(lane2_w), .lane2_out(dout[2]), .lane2_oe_out(oe[2]),
		.lane3_in(lane3_w), .lane3_out(dout[3]), .lane3_oe_out(oe[3]),
		.array_byte_in(array_byte_in), .status_out(status_out),
		.standby_out(standby_out), .powered_down_out(powered_down_out));

	spi_host_model i_spi_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
		.pause_n_out(pause_n), .lane0_in(lane0_w), .lane1_in(lane1_w));

	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	always @(negedge pause_n) #8 paused_oe = oe[1];
	always @(posedge oe[3]) quad_seen = 1'b1;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic give_verdict;
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic run(input logic [7:0] op, input logic [23:0] tx, input int n_tx,
		input int n_rx, input int dual, input int hold, input logic mode3);
		i_spi_host_model.frame(op, tx, n_tx, n_rx, dual, hold, mode3, rx);
		// Gives the command crossing time to land before anyone looks
		repeat (10) @(posedge clock_in);
		check({12'h000, oe}, 16'h0000);
	endtask : run

	task automatic cmd(input logic [7:0] op);
		run(op, 24'h000000, 0, 0, 0, -1, 1'b0);
	endtask : cmd

	task automatic write_status(input logic [15:0] lo_hi);
		cmd(8'h06);
		run(8'h01, {lo_hi, 8'h00}, 16, 0, 0, -1, 1'b0);
		repeat (120) @(posedge clock_in);
	endtask : write_status

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_write_lockout;
		cmd(8'h06);
		check(status_out, 16'h0000);
		repeat (200) @(posedge clock_in);
		cmd(8'h06);
		check(status_out, 16'h0002);
	endtask : t_write_lockout

	task automatic t_status_read;
		run(8'h05, 24'h000000, 0, 16, 0, 5, 1'b1);
		check(rx, 16'h0202);
		check({15'h0000, paused_oe}, 16'h0000);
		run(8'h35, 24'h000000, 0, 8, 0, -1, 1'b0);
		check(rx, 16'h0000);
	endtask : t_status_read

	task automatic t_erase;
		run(8'h20, 24'h001000, 24, 0, 0, -1, 1'b0);
		check(status_out, 16'h0003);
		check({15'h0000, standby_out}, 16'h0000);
		repeat (120) @(posedge clock_in);
		check(status_out, 16'h0000);
		check({15'h0000, standby_out}, 16'h0001);
		run(8'h20, 24'h002000, 24, 0, 0, -1, 1'b0);
		check(status_out, 16'h0000);
	endtask : t_erase

	task automatic t_dual;
		@(posedge clock_in) array_byte_in <= 8'hA5;
		run(8'h3B, 24'h000000, 32, 4, 1, -1, 1'b0);
		check(rx, 16'h00A5);
		run(8'hBB, 24'h000000, 16, 4, 1, -1, 1'b0);
		check(rx, 16'h00A5);
	endtask : t_dual

	task automatic t_quad(input logic seen);
		logic [7:0] ops [4] = '{8'h6B, 8'hEB, 8'hE7, 8'hE3};
		int pre [4] = '{32, 12, 10, 8};
		for (int i = 0; i < 4; i++) begin
			quad_seen = 1'b0;
			run(ops[i], 24'h000000, pre[i], 2, 0, -1, 1'b0);
			check({15'h0000, quad_seen}, {15'h0000, seen});
			// Lane1 carries bit 5 of each nibble-pair: A5h gives 1 then 0
			if (seen) check(rx, 16'h0002);
		end
	endtask : t_quad

	task automatic t_status_write;
		write_status({8'h80, 8'h00});
		check(status_out, 16'h0080);
		@(posedge clock_in) wp_n <= 1'b0;
		write_status({8'h7C, 8'h42});
		check(status_out & 16'hFFFC, 16'h0080);
		@(posedge clock_in) wp_n <= 1'b1;
		write_status({8'h7C, 8'h42});
		check(status_out, 16'h427C);
	endtask : t_status_write

	task automatic t_power_down;
		cmd(8'hB9);
		check({15'h0000, powered_down_out}, 16'h0001);
		cmd(8'h06);
		check(status_out, 16'h427C);
		run(8'hAB, 24'h000000, 32, 8, 0, -1, 1'b0);
		check(rx, 16'h00C3);
		check({15'h0000, powered_down_out}, 16'h0000);
	endtask : t_power_down

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		reset_n_in = 1'b0;
		array_byte_in = 8'h00;
		wp_n = 1'b1;
		paused_oe = 1'b1;
		quad_seen = 1'b0;
		repeat (8) @(posedge clock_in);
		check(status_out, 16'h0000);
		check({12'h000, oe}, 16'h0000);
		reset_n_in <= 1'b1;
		t_write_lockout();
		t_status_read();
		t_erase();
		t_dual();
		t_quad(1'b0);
		t_status_write();
		t_quad(1'b1);
		t_power_down();
		give_verdict();
	end

	// Whole run needs well under 100 us of system time
	initial begin
		#500000;
		n_errors++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
